// >>> verilog/pbp_bank.sv
// one interrupt bank: init sequence, op words, status, mask and vectors
//
// Functional notes
// - four 8-bit init words; the second reads back, the rest write only.
// - first init word sets sensing, single or cascade, and fourth word need.
// - slave map word taken only when cascade mode was chosen.
// - fourth init word taken only when the first word asked for it.
// - compat word steers nothing; it is only stored for read-back.
// - any compat word write raises the level 1.5 request in bank A.
// - reading a compat word clears level 1.5; host reads all three.
// - compat word written at one address and read at another.
// - slave map bits alter vector output during acknowledge.
// - fourth word selects auto end-of-service and special nesting.
// - after init the bank runs fully nested and accepts requests.
// - op words 2 and 3 are 8-bit and write only; op word 1 reads back as the mask.
// - op word 1 loads the mask; mask read returns masked levels.
// - op word 2 carries a level used for specific clear or priority.
// - op word 2 runs none, non-specific or specific end, and rotations.
// - op word 3 selects request or service read, poll wins over both.
// - op word 3 sets or clears special mask mode.
// - status read gives poll code, pending requests or in-service levels.
// - each input has an 8-bit vector driven out on pin acknowledge, unless a slave in cascade supplies it.
// - words told apart by address, sequence position and marker bits.
// - first init word resets edges, masks, priority, mask mode, reads.
// - base+0 command/status, base+1 data/mask, base+2 compat read.
// - the read after a poll acts as an acknowledge.
// - status selection persists; a poll covers only the next read.
// - request pins are active low and shown inverted as ones.
`timescale 1ns/10ps
module pbp_bank
	import pbp_pkg::*;
#(
	parameter logic [7:0] BANK_BASE = 8'h20,
	parameter bit         IS_BANK_A = 1'b0,
	parameter logic [7:0] VEC_RST   = 8'h00
) (
	input  wire logic       clk_sys_i,
	input  wire logic       reset_i,
	input  wire logic [7:0] io_addr_i,
	input  wire logic       io_wr_i,
	input  wire logic       io_rd_i,
	input  wire logic [7:0] io_wdata_i,
	output logic      [7:0] io_rdata_o,
	output logic            io_rvalid_o,
	input  wire logic [7:0] req_n_i,
	input  wire logic       ack_i,
	output logic            int_o,
	output logic      [7:0] ack_vector_o,
	output logic            ack_vec_drive_o,
	output logic            ack_valid_o,
	output logic      [2:0] ack_level_o,
	input  wire logic       compat_wr_other_i,
	input  wire logic       compat_rd_other_i,
	output logic            compat_wr_o,
	output logic            compat_rd_o,
	output logic            level_mode_o,
	output logic            cascade_o,
	output logic            aeoi_o,
	output logic            sfnm_o
);
	pbp_prio_if pr ();

	pbp_init_st_t st_r;
	pbp_init_st_t st_nxt;
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [7:0] prev_r;
	logic [7:0] irr_r;
	logic [7:0] isr_r;
	logic [7:0] mask_r;
	logic [7:0] compat_r;
	logic [7:0] slave_map_r;
	logic [7:0] vec_r [8];
	logic [2:0] lowest_r;
	logic       level_mode_r;
	logic       single_r;
	logic       need_nest_r;
	logic       aeoi_r;
	logic       sfnm_r;
	logic       rot_aeoi_r;
	logic       smm_r;
	logic       read_isr_r;
	logic       poll_pend_r;
	logic       compat_req_r;

	// address decode
	wire [7:0] ofs       = 8'(io_addr_i - BANK_BASE);
	wire       sel_cmd   = (ofs == PBP_OFS_CMD);
	wire       sel_data  = (ofs == PBP_OFS_DATA);
	wire       sel_cpt   = (ofs == PBP_OFS_COMPAT);
	wire       sel_vec   = (ofs >= PBP_OFS_VEC) && (ofs < 8'(PBP_OFS_VEC + PBP_VEC_SPAN));
	wire [2:0] vec_idx   = ofs[2:0];
	wire       wr_cmd    = io_wr_i && sel_cmd;
	wire       wr_data   = io_wr_i && sel_data;
	// marker bits split the command offset
	wire       wr_init_word_trigger_cascade   = wr_cmd && io_wdata_i[PBP_INIT_WORD_TRIGGER_CASCADE_ID];
	wire       wr_op_word_eoi_rotate   = wr_cmd && !io_wdata_i[PBP_INIT_WORD_TRIGGER_CASCADE_ID] && !io_wdata_i[PBP_OCW_SEL];
	wire       wr_op_word_read_poll   = wr_cmd && !io_wdata_i[PBP_INIT_WORD_TRIGGER_CASCADE_ID] && io_wdata_i[PBP_OCW_SEL];
	// data offset follows the sequence position
	wire       wr_compat = wr_data && (st_r == PBP_ST_WAIT_COMPAT);
	wire       wr_slave  = wr_data && (st_r == PBP_ST_WAIT_SLAVE);
	wire       wr_nest   = wr_data && (st_r == PBP_ST_WAIT_NEST);
	wire       wr_mask   = wr_data && ((st_r == PBP_ST_READY) || (st_r == PBP_ST_UNINIT));
	wire       rd_status = io_rd_i && sel_cmd;
	// compat word read at its own address
	wire       rd_compat = io_rd_i && sel_cpt;
	wire       rd_poll   = rd_status && poll_pend_r;
	wire       ready     = (st_r == PBP_ST_READY);

	// op word 2 fields
	wire [2:0] op_word_eoi_rotate_cmd  = {io_wdata_i[PBP_OP_WORD_EOI_ROTATE_R], io_wdata_i[PBP_OP_WORD_EOI_ROTATE_SL],
		io_wdata_i[PBP_OP_WORD_EOI_ROTATE_EOI]};
	wire [2:0] op_word_eoi_rotate_lvl  = io_wdata_i[2:0];

	// pins inverted so a request reads as one
	wire [7:0] pin_req   = ~sync2_r;
	wire [7:0] raw_req   = (IS_BANK_A && compat_req_r) ?
		(pin_req | (8'h01 << PBP_COMPAT_LVL)) : pin_req;
	wire [7:0] edge_rise = raw_req & ~prev_r;

	// prio resolver hookup
	assign pr.req     = irr_r & ~mask_r;
	assign pr.in_service_register     = isr_r;
	assign pr.same_ok = sfnm_r ? slave_map_r : PBP_BYTE_ZERO;
	assign pr.lowest  = lowest_r;
	assign pr.special_mask_select     = smm_r;

	pbp_resolve u_resolve (
		.pr (pr.resolver)
	);

	// acknowledge by pin or by the read after a poll
	// poll read acts as acknowledge
	wire       take_ack  = (ack_i || rd_poll) && ready;
	wire       take_hit  = take_ack && pr.req_hit;
	wire [7:0] take_bit  = 8'h01 << pr.req_lvl;

	// end-of-service decode
	// non-specific, specific and rotating ends
	wire       ns_eoi    = wr_op_word_eoi_rotate && ((op_word_eoi_rotate_cmd == PBP_CMD_NS_EOI)
		|| (op_word_eoi_rotate_cmd == PBP_CMD_ROT_NS_EOI));
	// level field used for specific end or priority
	wire       sp_eoi    = wr_op_word_eoi_rotate && ((op_word_eoi_rotate_cmd == PBP_CMD_SP_EOI)
		|| (op_word_eoi_rotate_cmd == PBP_CMD_ROT_SP_EOI));
	wire [7:0] eoi_clr   = ns_eoi ? (pr.isr_hit ? (8'h01 << pr.isr_lvl) : PBP_BYTE_ZERO)
		: (sp_eoi ? (8'h01 << op_word_eoi_rotate_lvl) : PBP_BYTE_ZERO);
	wire       rot_ns    = wr_op_word_eoi_rotate && (op_word_eoi_rotate_cmd == PBP_CMD_ROT_NS_EOI) && pr.isr_hit;
	wire       rot_lvl   = wr_op_word_eoi_rotate && ((op_word_eoi_rotate_cmd == PBP_CMD_ROT_SP_EOI)
		|| (op_word_eoi_rotate_cmd == PBP_CMD_SET_PRIO));
	wire       rot_auto  = take_hit && aeoi_r && rot_aeoi_r;

	// auto end leaves the service bit clear
	wire [7:0] isr_set   = (take_hit && !aeoi_r) ? take_bit : PBP_BYTE_ZERO;
	wire [7:0] isr_nxt   = (isr_r & ~eoi_clr) | isr_set;
	wire [2:0] lowest_nxt = rot_ns ? pr.isr_lvl : (rot_lvl ? op_word_eoi_rotate_lvl
		: (rot_auto ? pr.req_lvl : lowest_r));

	// request register: edge or level capture, ack clears edge bits
	// an edge-latched bit also drops once its request goes away, so a withdrawn
	// request (level 1.5 read back) does not linger in the status
	wire [7:0] irr_clr   = (take_hit && !level_mode_r) ? take_bit : PBP_BYTE_ZERO;
	wire [7:0] irr_edge  = ((irr_r & ~irr_clr) | edge_rise) & raw_req;
	wire [7:0] irr_nxt   = level_mode_r ? raw_req : irr_edge;

	// level 1.5 request: set wins over clear
	wire       cpt_set   = wr_compat || compat_wr_other_i;
	wire       cpt_clr   = rd_compat || compat_rd_other_i;
	wire       cpt_nxt   = cpt_set || (compat_req_r && !cpt_clr);

	wire [7:0] poll_word = {pr.req_hit, 4'h0, pr.req_hit ? pr.req_lvl : 3'h0};
	wire [7:0] stat_word = poll_pend_r ? poll_word : (read_isr_r ? isr_r : irr_r);
	// only the compat init word reads back
	wire [7:0] rd_word   = sel_cmd ? stat_word
		: (sel_data ? mask_r : (sel_cpt ? compat_r : (sel_vec ? vec_r[vec_idx]
		: PBP_BYTE_ZERO)));
	wire       rd_hit    = sel_cmd || sel_data || sel_cpt || sel_vec;

	// init sequence next state
	// first word picks the path through the sequence
	always_comb begin
		st_nxt = st_r;
		if (wr_init_word_trigger_cascade) begin
			st_nxt = PBP_ST_WAIT_COMPAT;
		end else if (wr_data) begin
			case (st_r)
				PBP_ST_WAIT_COMPAT: begin
					// slave map only in cascade mode
					if (!single_r) begin
						st_nxt = PBP_ST_WAIT_SLAVE;
					end else if (need_nest_r) begin
						st_nxt = PBP_ST_WAIT_NEST;
					end else begin
						st_nxt = PBP_ST_READY;
					end
				end
				PBP_ST_WAIT_SLAVE: begin
					st_nxt = need_nest_r ? PBP_ST_WAIT_NEST : PBP_ST_READY;
				end
				PBP_ST_WAIT_NEST: begin
					st_nxt = PBP_ST_READY;
				end
				default: begin
					st_nxt = st_r;
				end
			endcase
		end
	end

	// pin synchroniser and sequence state
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			sync1_r <= PBP_BYTE_ONES;
			sync2_r <= PBP_BYTE_ONES;
			st_r    <= PBP_ST_UNINIT;
		end else begin
			sync1_r <= req_n_i;
			sync2_r <= sync1_r;
			st_r    <= st_nxt;
		end
	end

	// first init word and its side effects
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			level_mode_r <= 1'b0;
			single_r     <= 1'b1;
			need_nest_r  <= 1'b0;
			prev_r       <= PBP_BYTE_ONES;
			mask_r       <= PBP_BYTE_ZERO;
			smm_r        <= 1'b0;
			read_isr_r   <= 1'b0;
		end else if (wr_init_word_trigger_cascade) begin
			level_mode_r <= io_wdata_i[PBP_INIT_WORD_TRIGGER_CASCADE_LTIM];
			single_r     <= io_wdata_i[PBP_INIT_WORD_TRIGGER_CASCADE_SNGL];
			need_nest_r  <= io_wdata_i[PBP_INIT_WORD_TRIGGER_CASCADE_IC4];
			// edges rearmed, masks cleared, irr reads
			prev_r       <= PBP_BYTE_ONES;
			mask_r       <= PBP_BYTE_ZERO;
			smm_r        <= 1'b0;
			read_isr_r   <= 1'b0;
		end else begin
			prev_r <= raw_req;
			// op word 1 loads the mask
			if (wr_mask) begin
				mask_r <= io_wdata_i;
			end
			if (wr_op_word_read_poll && io_wdata_i[PBP_OP_WORD_READ_POLL_SPECIAL_MASK_WRITE_ENABLE]) begin
				smm_r <= io_wdata_i[PBP_OP_WORD_READ_POLL_SMM];
			end
			if (wr_op_word_read_poll && io_wdata_i[PBP_OP_WORD_READ_POLL_RR]) begin
				read_isr_r <= io_wdata_i[PBP_OP_WORD_READ_POLL_RIS];
			end
		end
	end

	// remaining init words
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			compat_r    <= PBP_BYTE_ZERO;
			slave_map_r <= PBP_BYTE_ZERO;
			aeoi_r      <= 1'b0;
			sfnm_r      <= 1'b0;
		end else begin
			if (wr_compat) begin
				compat_r <= io_wdata_i;
			end
			if (wr_slave) begin
				slave_map_r <= io_wdata_i;
			end
			// no fourth word means no auto end
			if (wr_init_word_trigger_cascade) begin
				aeoi_r <= 1'b0;
				sfnm_r <= 1'b0;
			end else if (wr_nest) begin
				aeoi_r <= io_wdata_i[PBP_INIT_WORD_EOI_NESTING_AEOI];
				sfnm_r <= io_wdata_i[PBP_INIT_WORD_EOI_NESTING_SFNM];
			end
		end
	end

	// priority, service, request and poll state
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			lowest_r    <= PBP_LOWEST_RST;
			rot_aeoi_r  <= 1'b0;
			isr_r       <= PBP_BYTE_ZERO;
			irr_r       <= PBP_BYTE_ZERO;
			poll_pend_r <= 1'b0;
		end else begin
			lowest_r <= wr_init_word_trigger_cascade ? PBP_LOWEST_RST : lowest_nxt;
			isr_r    <= wr_init_word_trigger_cascade ? PBP_BYTE_ZERO : isr_nxt;
			irr_r    <= irr_nxt;
			if (wr_op_word_eoi_rotate && (op_word_eoi_rotate_cmd == PBP_CMD_ROT_AEOI_SET)) begin
				rot_aeoi_r <= 1'b1;
			end else if (wr_op_word_eoi_rotate && (op_word_eoi_rotate_cmd == PBP_CMD_ROT_AEOI_CLR)) begin
				rot_aeoi_r <= 1'b0;
			end
			// poll flag wins the next status read
			if (wr_op_word_read_poll) begin
				poll_pend_r <= io_wdata_i[PBP_OP_WORD_READ_POLL_P];
			end else if (rd_status || wr_init_word_trigger_cascade) begin
				poll_pend_r <= 1'b0;
			end
		end
	end

	for (genvar g = 0; g < 8; g++) begin : g_vec
		always_ff @(posedge clk_sys_i) begin
			if (reset_i) begin
				vec_r[g] <= VEC_RST;
			end else if (io_wr_i && sel_vec && (vec_idx == 3'(g))) begin
				vec_r[g] <= io_wdata_i;
			end
		end
	end

	// bus read data, acknowledge outputs and level 1.5 request
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			io_rdata_o      <= PBP_BYTE_ZERO;
			io_rvalid_o     <= 1'b0;
			int_o           <= 1'b0;
			ack_vector_o    <= PBP_BYTE_ZERO;
			ack_vec_drive_o <= 1'b0;
			ack_valid_o     <= 1'b0;
			ack_level_o     <= 3'h0;
			compat_req_r    <= 1'b0;
			compat_wr_o     <= 1'b0;
			compat_rd_o     <= 1'b0;
		end else begin
			io_rdata_o  <= io_rd_i ? rd_word : io_rdata_o;
			io_rvalid_o <= io_rd_i && rd_hit;
			// requests raise the output only once ready
			int_o       <= ready && pr.req_hit;
			ack_valid_o <= ack_i && ready;
			if (ack_i && ready) begin
				ack_level_o     <= pr.req_hit ? pr.req_lvl : PBP_SPURIOUS;
				ack_vector_o    <= vec_r[pr.req_hit ? pr.req_lvl : PBP_SPURIOUS];
				// a slave on this input supplies the vector
				ack_vec_drive_o <= !(pr.req_hit && !single_r && slave_map_r[pr.req_lvl]);
			end
			compat_req_r <= IS_BANK_A ? cpt_nxt : 1'b0;
			compat_wr_o  <= wr_compat;
			compat_rd_o  <= rd_compat;
		end
	end

	assign level_mode_o = level_mode_r;
	assign cascade_o    = !single_r;
	assign aeoi_o       = aeoi_r;
	assign sfnm_o       = sfnm_r;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	sequence s_mask_then_read;
		wr_mask ##1 (io_rd_i && sel_data);
	endsequence

	AST_INIT_WORD_TRIGGER_CASCADE_DEFAULTS: assert property (
		wr_init_word_trigger_cascade |=> (mask_r == PBP_BYTE_ZERO) && !smm_r && !read_isr_r
			&& (lowest_r == PBP_LOWEST_RST) && (prev_r == PBP_BYTE_ONES))
		else $error("first init word did not restore defaults");
	AST_SLAVE_SKIPPED: assert property (
		wr_compat && single_r && !need_nest_r |=> (st_r == PBP_ST_READY))
		else $error("single bank waited for slave or fourth word");
	AST_NEST_ONLY_ASKED: assert property (
		(st_r == PBP_ST_WAIT_NEST) |-> need_nest_r)
		else $error("fourth word expected without request");
	AST_COMPAT_RAISE: assert property (
		IS_BANK_A && cpt_set |=> compat_req_r)
		else $error("compat write did not raise level 1.5");
	AST_COMPAT_CLEAR: assert property (
		rd_compat && !cpt_set |=> !compat_req_r)
		else $error("compat read did not clear level 1.5");
	AST_MASK_READBACK: assert property (
		s_mask_then_read |=> (io_rdata_o == $past(io_wdata_i, 2)) && io_rvalid_o)
		else $error("mask read did not return written value");
	AST_POLL_WINS: assert property (
		wr_op_word_read_poll && io_wdata_i[PBP_OP_WORD_READ_POLL_P] ##1 rd_status
			|=> (io_rdata_o[PBP_POLL_HIT] == $past(pr.req_hit)))
		else $error("poll result not returned");
	AST_POLL_ONCE: assert property (
		rd_status && !wr_op_word_read_poll |=> !poll_pend_r)
		else $error("poll covered more than one read");
	AST_ACK_SERVICE: assert property (
		take_hit && !aeoi_r && !wr_init_word_trigger_cascade |=> isr_r[$past(pr.req_lvl)])
		else $error("acknowledge did not set in-service bit");
	AST_NOT_READY_QUIET: assert property (
		(st_r != PBP_ST_READY) |=> !int_o)
		else $error("interrupt raised before init done");
endmodule

// >>> verilog/pbp_pkg.sv
// constants and types for one programmable interrupt bank
package pbp_pkg;
	// i/o offsets from the bank base address
	localparam logic [7:0] PBP_OFS_CMD    = 8'h00; // init word 1, op words 2/3, status
	localparam logic [7:0] PBP_OFS_DATA   = 8'h01; // init words 2-4, mask
	localparam logic [7:0] PBP_OFS_COMPAT = 8'h02; // compat word read-back
	localparam logic [7:0] PBP_OFS_VEC    = 8'h08; // first vector register
	localparam logic [7:0] PBP_VEC_SPAN   = 8'h08; // one vector per input

	// init word 1 fields
	localparam int PBP_INIT_WORD_TRIGGER_CASCADE_ID   = 4; // marks init word 1 at the command offset
	localparam int PBP_INIT_WORD_TRIGGER_CASCADE_LTIM = 3; // level sensing
	localparam int PBP_INIT_WORD_TRIGGER_CASCADE_SNGL = 1; // single bank, no slave map word
	localparam int PBP_INIT_WORD_TRIGGER_CASCADE_IC4  = 0; // fourth word follows
	// init word 4 fields
	localparam int PBP_INIT_WORD_EOI_NESTING_AEOI = 1;
	localparam int PBP_INIT_WORD_EOI_NESTING_SFNM = 4;
	// op word select and fields
	localparam int PBP_OCW_SEL   = 3; // 0: op word 2, 1: op word 3
	localparam int PBP_OP_WORD_EOI_ROTATE_R    = 7;
	localparam int PBP_OP_WORD_EOI_ROTATE_SL   = 6;
	localparam int PBP_OP_WORD_EOI_ROTATE_EOI  = 5;
	localparam int PBP_OP_WORD_READ_POLL_SPECIAL_MASK_WRITE_ENABLE = 6;
	localparam int PBP_OP_WORD_READ_POLL_SMM  = 5;
	localparam int PBP_OP_WORD_READ_POLL_P    = 2;
	localparam int PBP_OP_WORD_READ_POLL_RR   = 1;
	localparam int PBP_OP_WORD_READ_POLL_RIS  = 0;
	localparam int PBP_POLL_HIT  = 7; // request flag in the poll answer

	// op word 2 commands, {R, SL, END_OF_SERVICE}
	localparam logic [2:0] PBP_CMD_ROT_AEOI_CLR = 3'h0;
	localparam logic [2:0] PBP_CMD_NS_EOI       = 3'h1;
	localparam logic [2:0] PBP_CMD_SP_EOI       = 3'h3;
	localparam logic [2:0] PBP_CMD_ROT_AEOI_SET = 3'h4;
	localparam logic [2:0] PBP_CMD_ROT_NS_EOI   = 3'h5;
	localparam logic [2:0] PBP_CMD_SET_PRIO     = 3'h6;
	localparam logic [2:0] PBP_CMD_ROT_SP_EOI   = 3'h7;

	// reset and fixed values
	localparam logic [2:0] PBP_LOWEST_RST  = 3'h7; // input seven lowest
	localparam logic [2:0] PBP_SPURIOUS    = 3'h7; // level given when nothing requests
	localparam int         PBP_COMPAT_LVL  = 2;    // slot of the level 1.5 request
	localparam logic [7:0] PBP_BYTE_ZERO   = 8'h00;
	localparam logic [7:0] PBP_BYTE_ONES   = 8'hff;

	// initialization sequence position
	typedef enum logic [2:0] {
		PBP_ST_UNINIT,
		PBP_ST_WAIT_COMPAT,
		PBP_ST_WAIT_SLAVE,
		PBP_ST_WAIT_NEST,
		PBP_ST_READY
	} pbp_init_st_t;
endpackage

// >>> verilog/pbp_prio_if.sv
// priority resolution signals between the bank and its resolver
`timescale 1ns/10ps
interface pbp_prio_if;
	logic [7:0] req;     // unmasked pending requests
	logic [7:0] in_service_register;     // in-service levels
	logic [7:0] same_ok; // levels that may nest on themselves
	logic [2:0] lowest;  // lowest priority level
	logic       special_mask_select;     // special mask mode
	logic       req_hit;
	logic [2:0] req_lvl;
	logic       isr_hit;
	logic [2:0] isr_lvl;
	modport bank (output req, in_service_register, same_ok, lowest, special_mask_select, input req_hit, req_lvl, isr_hit, isr_lvl);
	modport resolver (input req, in_service_register, same_ok, lowest, special_mask_select, output req_hit, req_lvl, isr_hit, isr_lvl);
endinterface

// >>> verilog/pbp_resolve.sv
// rotating priority resolver for one bank
`timescale 1ns/10ps
module pbp_resolve
	import pbp_pkg::*;
(
	pbp_prio_if.resolver pr
);
	logic [2:0] walk_lvl;
	logic       blocked;
	logic       r_hit;
	logic [2:0] r_lvl;
	logic       s_hit;
	logic [2:0] s_lvl;

	// walk levels from highest priority (lowest+1) to lowest
	always_comb begin
		walk_lvl = 3'h0;
		blocked  = 1'b0;
		r_hit    = 1'b0;
		r_lvl    = 3'h0;
		s_hit    = 1'b0;
		s_lvl    = 3'h0;
		for (int i = 0; i < 8; i++) begin
			walk_lvl = 3'(pr.lowest + 3'(i + 1));
			if (!r_hit && !blocked && pr.req[walk_lvl]
				&& (!pr.in_service_register[walk_lvl] || pr.same_ok[walk_lvl])) begin
				r_hit = 1'b1;
				r_lvl = walk_lvl;
			end
			if (!s_hit && pr.in_service_register[walk_lvl]) begin
				s_hit = 1'b1;
				s_lvl = walk_lvl;
			end
			// special mask lets lower levels through
			if (pr.in_service_register[walk_lvl] && !pr.special_mask_select) begin
				blocked = 1'b1;
			end
		end
	end

	assign pr.req_hit = r_hit;
	assign pr.req_lvl = r_lvl;
	assign pr.isr_hit = s_hit;
	assign pr.isr_lvl = s_lvl;
endmodule

// >>> tb/pbp_host_model.sv
// host-side model that issues i/o reads and writes to one bank
`timescale 1ns/10ps
module pbp_host_model (
	input  wire logic       clk_sys_i,
	output logic      [7:0] io_addr_o,
	output logic            io_wr_o,
	output logic            io_rd_o,
	output logic      [7:0] io_wdata_o,
	input  wire logic [7:0] io_rdata_i,
	input  wire logic       io_rvalid_i
);
	// bus idle at time zero
	initial begin
		io_addr_o = 8'h00;
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		io_wdata_o = 8'h00;
	end

	// one-cycle write strobe launched at the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		io_addr_o = a;
		io_wdata_o = d;
		io_wr_o = 1'b1;
		@(negedge clk_sys_i);
		io_wr_o = 1'b0;
		io_wdata_o = ~d; // released data must not look held
	endtask

	// one-cycle read strobe; answer taken in the cycle after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge clk_sys_i);
		io_addr_o = a;
		io_rd_o = 1'b1;
		@(negedge clk_sys_i);
		io_rd_o = 1'b0;
		d = io_rdata_i;
		v = io_rvalid_i;
	endtask
endmodule

// >>> tb/tb_pbp_bank.sv
// self-checking bench for one interrupt bank
`timescale 1ns/10ps
module tb_pbp_bank;
	import pbp_pkg::*;
	localparam logic [7:0] BASE = 8'h20;
	logic       clk_sys_i;
	logic       reset_i;
	logic [7:0] io_addr;
	logic       io_wr;
	logic       io_rd;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic       io_rvalid;
	logic [7:0] req_n_i;
	logic       ack_i;
	logic       int_o;
	logic [7:0] ack_vector_o;
	logic       ack_vec_drive_o;
	logic       ack_valid_o;
	logic [2:0] ack_level_o;
	logic       compat_wr_other_i;
	logic       compat_rd_other_i;
	logic       level_mode_o;
	logic       cascade_o;
	logic       aeoi_o;
	logic       sfnm_o;
	logic [7:0] rd_d;
	logic       rd_v;
	int         miscompares;
	int         check_count;

	pbp_host_model host (.clk_sys_i(clk_sys_i), .io_addr_o(io_addr), .io_wr_o(io_wr),
		.io_rd_o(io_rd), .io_wdata_o(io_wdata), .io_rdata_i(io_rdata),
		.io_rvalid_i(io_rvalid));

	pbp_bank #(.BANK_BASE(BASE), .IS_BANK_A(1'b1), .VEC_RST(8'h00)) dut (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .io_addr_i(io_addr), .io_wr_i(io_wr),
		.io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
		.io_rvalid_o(io_rvalid), .req_n_i(req_n_i), .ack_i(ack_i), .int_o(int_o),
		.ack_vector_o(ack_vector_o), .ack_vec_drive_o(ack_vec_drive_o),
		.ack_valid_o(ack_valid_o), .ack_level_o(ack_level_o),
		.compat_wr_other_i(compat_wr_other_i), .compat_rd_other_i(compat_rd_other_i),
		.compat_wr_o(), .compat_rd_o(), .level_mode_o(level_mode_o),
		.cascade_o(cascade_o), .aeoi_o(aeoi_o), .sfnm_o(sfnm_o));

	// 40 MHz system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	// compare one byte and report a mismatch
	task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// read a mapped place and compare valid and data
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, rd_d, rd_v);
		chk(what, {7'h00, rd_v}, 8'h01);
		chk(what, rd_d, exp);
	endtask

	// wait a given number of falling clock edges
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	// verdict and end of run
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// watchdog well beyond the expected run length
	initial begin
		#(25 * 20000);
		miscompares++;
		final_report();
	end

	// main sequence
	initial begin
		miscompares = 0;
		check_count = 0;
		reset_i = 1'b1;
		req_n_i = 8'hff;
		ack_i = 1'b0;
		compat_wr_other_i = 1'b0;
		compat_rd_other_i = 1'b0;
		repeat (20) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		reset_i = 1'b0;
		// unmapped place gives no valid and zero data
		host.rd(BASE + 8'h05, rd_d, rd_v);
		chk("unmapped", {7'h00, rd_v}, 8'h00);
		chk("unmapped", rd_d, 8'h00);
		// data write before any init lands in the mask
		host.wr(BASE + PBP_OFS_DATA, 8'h3c);
		rd_chk("mask uninit", BASE + PBP_OFS_DATA, 8'h3c);
		// single bank with fourth word: init1, compat, fourth
		host.wr(BASE + PBP_OFS_CMD, 8'h13);
		rd_chk("mask cleared", BASE + PBP_OFS_DATA, 8'h00);
		host.wr(BASE + PBP_OFS_DATA, 8'h5a);
		host.wr(BASE + PBP_OFS_DATA, 8'h12);
		idle(3);
		chk("aeoi", {7'h00, aeoi_o}, 8'h01);
		chk("sfnm", {7'h00, sfnm_o}, 8'h01);
		chk("cascade", {7'h00, cascade_o}, 8'h00);
		chk("level", {7'h00, level_mode_o}, 8'h00);
		chk("int", {7'h00, int_o}, 8'h01);
		rd_chk("status 1.5", BASE + PBP_OFS_CMD, 8'h04);
		rd_chk("compat", BASE + PBP_OFS_COMPAT, 8'h5a);
		rd_chk("mask after init", BASE + PBP_OFS_DATA, 8'h00);
		rd_chk("status clear", BASE + PBP_OFS_CMD, 8'h00);
		// level 1.5 set and cleared by other banks
		compat_wr_other_i = 1'b1;
		idle(1);
		compat_wr_other_i = 1'b0;
		idle(2);
		rd_chk("status other", BASE + PBP_OFS_CMD, 8'h04);
		compat_rd_other_i = 1'b1;
		idle(1);
		compat_rd_other_i = 1'b0;
		idle(2);
		rd_chk("status other clr", BASE + PBP_OFS_CMD, 8'h00);
		// cascade without fourth word: init1, compat, slave map, then mask
		host.wr(BASE + PBP_OFS_CMD, 8'h10);
		host.wr(BASE + PBP_OFS_DATA, 8'h00);
		host.wr(BASE + PBP_OFS_DATA, 8'h04);
		rd_chk("mask not slave", BASE + PBP_OFS_DATA, 8'h00);
		chk("cascade2", {7'h00, cascade_o}, 8'h01);
		chk("aeoi2", {7'h00, aeoi_o}, 8'h00);
		host.wr(BASE + PBP_OFS_DATA, 8'h81);
		rd_chk("mask no fourth", BASE + PBP_OFS_DATA, 8'h81);
		host.wr(BASE + PBP_OFS_DATA, 8'h00);
		rd_chk("compat2", BASE + PBP_OFS_COMPAT, 8'h00);
		// vector registers per input
		for (int i = 0; i < 8; i++) begin
			host.wr(BASE + PBP_OFS_VEC + 8'(i), 8'h40 + 8'(i));
		end
		for (int i = 0; i < 8; i++) begin
			rd_chk("vector", BASE + PBP_OFS_VEC + 8'(i), 8'h40 + 8'(i));
		end
		// edge request on input 5, poll with register read also asked
		req_n_i[5] = 1'b0;
		idle(5);
		rd_chk("irr", BASE + PBP_OFS_CMD, 8'h20);
		chk("int req", {7'h00, int_o}, 8'h01);
		host.wr(BASE + PBP_OFS_CMD, 8'h0e);
		rd_chk("poll", BASE + PBP_OFS_CMD, 8'h85);
		rd_chk("irr after poll", BASE + PBP_OFS_CMD, 8'h00);
		host.wr(BASE + PBP_OFS_CMD, 8'h0b);
		rd_chk("isr", BASE + PBP_OFS_CMD, 8'h20);
		rd_chk("isr again", BASE + PBP_OFS_CMD, 8'h20);
		host.wr(BASE + PBP_OFS_CMD, 8'h20);
		rd_chk("isr ns end", BASE + PBP_OFS_CMD, 8'h00);
		req_n_i[5] = 1'b1;
		host.wr(BASE + PBP_OFS_CMD, 8'h0c);
		rd_chk("poll none", BASE + PBP_OFS_CMD, PBP_BYTE_ZERO);
		// acknowledge of input 3, then input 2 which carries a slave
		for (int i = 3; i > 1; i--) begin
			req_n_i[i] = 1'b0;
			idle(5);
			ack_i = 1'b1;
			idle(1);
			ack_i = 1'b0;
			chk("ack valid", {7'h00, ack_valid_o}, 8'h01);
			chk("ack level", {5'h00, ack_level_o}, 8'(i));
			chk("ack drive", {7'h00, ack_vec_drive_o}, {7'h00, i != 2});
			chk("ack vector", ack_vector_o, 8'h40 + 8'(i));
		end
		host.wr(BASE + PBP_OFS_CMD, 8'h0b);
		rd_chk("isr nested", BASE + PBP_OFS_CMD, 8'h0c);
		host.wr(BASE + PBP_OFS_CMD, 8'h63);
		rd_chk("isr sp end", BASE + PBP_OFS_CMD, 8'h04);
		req_n_i = 8'hff;
		idle(3);
		final_report();
	end
endmodule
